//--- bench/modem_model.sv
// line-side modem model for both ports: status pins and serial data
// assumes the bench names the wanted levels; slow_i adds a cycle
`timescale 1ns/1ns
module modem_model
(
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // wanted levels, serial lines above status pins, and pacing
  input wire logic [9:0] want_i,
  input wire logic slow_i,
  // pins towards the device, idle high
  output modem_pkg::modem_in_s [modem_pkg::NPORT-1:0] modem_n_o,
  output logic [1:0] serial_o
);
  import modem_pkg::*;
  logic [9:0] stage;
  // a data set answers at its own pace, one or two cycles late
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      stage <= 10'h3FF;
      {serial_o, modem_n_o} <= 10'h3FF;
    end
    else
    begin
      stage <= want_i;
      {serial_o, modem_n_o} <= slow_i ? stage : want_i;
    end
  end
endmodule : modem_model

//--- bench/modem_monitor.sv
// checker on the top ports of the modem signal block
// assumes one clock domain; register images are rebuilt from writes
`timescale 1ns/1ns
module modem_monitor
(
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // register port
  input wire logic [modem_pkg::ADDR_W-1:0] addr_i,
  input wire logic [modem_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [modem_pkg::DATA_W-1:0] rd_data_o,
  // pins
  input modem_pkg::modem_in_s [modem_pkg::NPORT-1:0] modem_n_i,
  input wire logic [modem_pkg::NPORT-1:0] tx_bit_i,
  input wire logic [modem_pkg::NPORT-1:0] terminal_ready_n_o,
  input wire logic [modem_pkg::NPORT-1:0] request_send_n_o,
  input wire logic [modem_pkg::NPORT-1:0] port_serial_out_o,
  input wire logic irq_o
);
  import modem_pkg::*;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  logic [7:0] mcr0;
  logic [7:0] mcr1;
  logic [1:0] mask;
  // control and mask images, so pins can be predicted from the bus
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      mcr0 <= MCR_RESET;
      mcr1 <= MCR_RESET;
      mask <= IRQ_RESET;
    end
    else if (wr_i)
    begin
      if (addr_i == MCR_BASE) mcr0 <= wr_data_i & MCR_WMASK;
      if (addr_i == MCR_BASE + PORT_STRIDE) mcr1 <= wr_data_i & MCR_WMASK;
      if (addr_i == IRQ_MASK_OFF) mask <= wr_data_i[1:0];
    end
  end
  a_dtr_follows: assert property (
    terminal_ready_n_o[0] == ~($past(mcr0[0]) & ~$past(mcr0[MCR_LOOP])))
    else $error("terminal ready of port 0 wrong");
  a_rts_follows: assert property (
    request_send_n_o[1] == ~($past(mcr1[1]) & ~$past(mcr1[MCR_LOOP])))
    else $error("request to send of port 1 wrong");
  a_reset_idle: assert property (disable iff (1'h0)
    !nrst_i |-> &{terminal_ready_n_o, request_send_n_o, port_serial_out_o})
    else $error("outputs not idle in reset");
  a_tx_path: assert property (
    port_serial_out_o[0] ==
    ($past(mcr0[MCR_LOOP]) ? MARK : $past(tx_bit_i[0])))
    else $error("serial out of port 0 wrong");
  a_level_read: assert property (
    ($stable(modem_n_i[0]) && !wr_i) [*6] ##0 rd_i && addr_i == STATUS_BASE
    && !mcr0[MCR_LOOP] |=> rd_data_o[7:4] == ~$past(modem_n_i[0]))
    else $error("status levels of port 0 wrong");
  a_flags_once: assert property (
    ($stable(modem_n_i[0]) && !wr_i) [*6] ##0 rd_i && addr_i == STATUS_BASE
    ##1 rd_i && addr_i == STATUS_BASE |=> rd_data_o[3:0] == FLAGS_RESET)
    else $error("change flags reported twice");
  a_irq_raise: assert property (
    $changed(modem_n_i[0]) && mask[0] && !mcr0[MCR_LOOP] && !wr_i
    |-> ##[1:6] irq_o)
    else $error("interrupt missing after status change");
  a_irq_masked: assert property (
    irq_o |-> (mask | $past(mask)) != IRQ_RESET)
    else $error("interrupt while all masked");
endmodule : modem_monitor

bind dual_uart_modem_signals modem_monitor modem_monitor_inst (.clock_i,
  .nrst_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .modem_n_i,
  .tx_bit_i, .terminal_ready_n_o, .request_send_n_o, .port_serial_out_o,
  .irq_o);

//--- bench/tb.sv
// self-checking bench of the dual-port modem signal block
// assumes the checker is bound to the top and the modem model on pins
`timescale 1ns/1ns
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin \
  err_total++; $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module tb;
  import modem_pkg::*;
  logic clock_i = 1'h0;
  logic nrst_i = 1'h1;
  logic [3:0] addr_i = 4'h0;
  logic [7:0] wr_data_i = 8'h00;
  logic wr_i = 1'h0;
  logic rd_i = 1'h0;
  logic uart_clk_i = 1'h0;
  logic [1:0] tx_bit_i = 2'h3;
  logic [9:0] want = 10'h3FF;
  logic slow = 1'h0;
  logic [7:0] rd_data_o, d, d0, d1;
  modem_in_s [NPORT-1:0] pins_n;
  logic [1:0] ser_in, dtr_n, rts_n, ser_out, rx, tick;
  logic irq_o;
  int err_total = 0;
  int check_count = 0;
  int ticks, p, i;
  dual_uart_modem_signals dual_uart_modem_signals_inst (.clock_i, .nrst_i,
    .addr_i, .wr_data_i, .wr_i, .rd_i, .rd_data_o, .uart_clk_i,
    .modem_n_i(pins_n), .port_serial_in_i(ser_in), .tx_bit_i,
    .terminal_ready_n_o(dtr_n), .request_send_n_o(rts_n),
    .port_serial_out_o(ser_out), .rx_bit_o(rx), .baud_tick_o(tick), .irq_o);
  modem_model modem_model_inst (.clock_i, .nrst_i, .want_i(want),
    .slow_i(slow), .modem_n_o(pins_n), .serial_o(ser_in));
  // system clock, and a uart clock of six system periods (below 5 MHz)
  initial forever #25 clock_i = ~clock_i;
  initial forever
  begin
    repeat (3) @(posedge clock_i);
    uart_clk_i <= ~uart_clk_i;
  end
  // verdict and end of run
  task automatic report_and_stop();
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : report_and_stop
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clock_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_i <= 1'h1;
    @(posedge clock_i);
    wr_i <= 1'h0;
  endtask : wr
  // two back-to-back reads of one address, answers in d0 and d1
  task automatic rd(input logic [3:0] a);
    @(posedge clock_i);
    addr_i <= a;
    rd_i <= 1'h1;
    @(posedge clock_i);
    @(posedge clock_i);
    rd_i <= 1'h0;
    d0 = rd_data_o;
    @(posedge clock_i);
    d1 = rd_data_o;
  endtask : rd
  // bounded wait for the interrupt line; a hang ends the run
  task automatic wait_irq(input logic lvl);
    int n;
    n = 0;
    while (irq_o !== lvl && n < 10)
    begin
      @(posedge clock_i);
      n++;
    end
    `CHK("irq", lvl, irq_o)
    if (irq_o !== lvl) report_and_stop();
  endtask : wait_irq
  // status image: inverted levels over change flags
  function automatic logic [7:0] exp_status(input logic [3:0] lv_n,
                                            input logic [3:0] fl);
    return {~lv_n, fl};
  endfunction : exp_status
  initial
  begin
    void'($urandom(32'hD4AC709F));
    #5 nrst_i = 1'h0;
    repeat (3) @(posedge clock_i);
    `CHK("dtr_n", 2'h3, dtr_n)
    `CHK("rts_n", 2'h3, rts_n)
    `CHK("txd", 2'h3, ser_out)
    nrst_i <= 1'h1;
    // random controls, loopback corners first, with serial traffic
    for (int n = 0; n < 12; n++)
    begin
      p = n % 2;
      d = (n < 2) ? 8'h13 : ((n < 4) ? 8'h03 : 8'($urandom));
      slow <= d[5];
      want[8 + p] <= d[6];
      tx_bit_i[p] <= d[7];
      wr(4'(MCR_BASE + PORT_STRIDE * p), d);
      repeat (5) @(posedge clock_i);
      `CHK("dtr_n", ~(d[0] & ~d[4]), dtr_n[p])
      `CHK("rts_n", ~(d[1] & ~d[4]), rts_n[p])
      `CHK("txd", d[4] | d[7], ser_out[p])
      `CHK("rxd", d[4] ? d[7] : d[6], rx[p])
      rd(4'(MCR_BASE + PORT_STRIDE * p));
      `CHK("mcr", d & MCR_WMASK, d0)
      // loopback feeds the status levels from the control bits
      rd(4'(STATUS_BASE + PORT_STRIDE * p));
      if (d[4]) `CHK("loop_lvl", {d[3], d[2], d[0], d[1]}, d0[7:4])
    end
    want <= 10'h3FF;
    wr(MCR_BASE, MCR_RESET);
    wr(MCR_BASE + PORT_STRIDE, MCR_RESET);
    repeat (8) @(posedge clock_i);
    rd(STATUS_BASE);
    `CHK("levels", 4'h0, d0[7:4])
    rd(STATUS_BASE + PORT_STRIDE);
    wr(IRQ_STAT_OFF, 8'h03);
    wr(IRQ_MASK_OFF, 8'h03);
    // every status input of both ports, falling then rising
    for (int k = 0; k < 16; k++)
    begin
      p = k / 8;
      i = k % 4;
      slow <= k[0];
      want[p * 4 + i] <= k[2];
      wait_irq(1'h1);
      rd(4'(STATUS_BASE + PORT_STRIDE * p));
      `CHK("status", exp_status(want[p*4 +: 4], 4'(1 << i)), d0)
      `CHK("status", exp_status(want[p*4 +: 4], FLAGS_RESET), d1)
      wr(IRQ_STAT_OFF, 8'(1 << p));
      wait_irq(1'h0);
    end
    // a masked change stays silent until the mask opens
    wr(IRQ_MASK_OFF, 8'h00);
    d = 8'($urandom) | 8'h01;
    want[7:0] <= want[7:0] ^ d;
    repeat (10) @(posedge clock_i);
    `CHK("irq", 1'h0, irq_o)
    rd(IRQ_STAT_OFF);
    `CHK("stat", {6'h00, |d[7:4], 1'h1}, d0)
    wr(IRQ_MASK_OFF, 8'h03);
    wait_irq(1'h1);
    rd(STATUS_BASE);
    `CHK("status", exp_status(want[3:0], d[3:0]), d0)
    wr(IRQ_STAT_OFF, 8'h03);
    wait_irq(1'h0);
    rd(4'hF);
    `CHK("unmapped", READ_ZERO, d0)
    // both ports tick once per 16 rising uart clock edges
    ticks = 0;
    repeat (960)
    begin
      @(posedge clock_i);
      ticks += tick[0] + tick[1];
    end
    `CHK("ticks", 1'h1, ticks >= 18 && ticks <= 20)
    report_and_stop();
  end
endmodule : tb

//--- inc/modem_pkg.sv
// constants, register map and carrier types for the dual-port modem block
// assumes one 20 MHz system clock; all offsets are word indices on a
// plain strobe port with 8-bit data
package modem_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int NPORT = 2;

  // register map: each port owns a stride of two words
  localparam logic [3:0] STATUS_BASE = 4'h0;
  localparam logic [3:0] MCR_BASE = 4'h1;
  localparam logic [3:0] PORT_STRIDE = 4'h2;
  localparam logic [3:0] IRQ_STAT_OFF = 4'h4;
  localparam logic [3:0] IRQ_MASK_OFF = 4'h5;

  // modem control fields
  localparam int MCR_DTR = 0;
  localparam int MCR_RTS = 1;
  localparam int MCR_OUT1 = 2;
  localparam int MCR_OUT2 = 3;
  localparam int MCR_LOOP = 4;
  localparam logic [7:0] MCR_RESET = 8'h00;
  localparam logic [7:0] MCR_WMASK = 8'h1F;

  // modem status: levels in [7:4], change flags in [3:0]
  localparam int STATUS_LVL_LSB = 4;
  localparam logic [3:0] FLAGS_RESET = 4'h0;

  localparam logic [7:0] READ_ZERO = 8'h00;
  localparam logic [1:0] IRQ_RESET = 2'h0;

  // serial line idles at marking; inactive handshake outputs are high
  localparam logic MARK = 1'b1;
  localparam logic INACTIVE_N = 1'b1;

  // rising uart clock edges per baud tick
  localparam logic [7:0] BAUD_DIV = 8'h10;
  localparam logic [7:0] BAUD_LAST = BAUD_DIV - 8'h01;

  // active-low modem inputs of one port
  typedef struct packed {
    logic carrier_detect_n;
    logic ring_indicate_n;
    logic dsr_n;
    logic cts_n;
  } modem_in_s;

  // synchroniser vector: uart clock, serial inputs, modem inputs
  localparam int SYNC_W = 1 + NPORT + NPORT * 4;
  localparam logic [SYNC_W-1:0] SYNC_RESET = 11'h7FE;

  // true when addr selects register base of port p
  function automatic logic port_hit(input logic [3:0] addr,
                                    input logic [3:0] base,
                                    input int p);
    port_hit = (addr == base + 4'(p) * PORT_STRIDE);
  endfunction : port_hit

endpackage : modem_pkg

//--- src/baud_tick.sv
// baud tick generator fed by the synchronised uart input clock
// assumes the uart clock runs below a quarter of the system clock
`timescale 1ns/1ns
module baud_tick
(
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // synchronised uart clock level
  input wire logic uart_clk_i,
  // one-cycle tick every BAUD_DIV rising uart clock edges
  output logic tick_o
);
  import modem_pkg::*;

  logic uart_prev;
  logic [7:0] count;
  logic rise;

  assign rise = uart_clk_i & ~uart_prev;

  // edge detect on the already synchronised level
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      uart_prev <= 1'b0;
    else
      uart_prev <= uart_clk_i;
  end

  // divide the uart clock down to the baud tick
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      count <= 8'h00;
      tick_o <= 1'b0;
    end
    else
    begin
      tick_o <= rise && (count == BAUD_LAST);
      if (rise)
        count <= (count == BAUD_LAST) ? 8'h00 : count + 8'h01;
    end
  end

endmodule : baud_tick

//--- src/dual_uart_modem_signals.sv
// top of the two-port modem signal block: register port, pin
// synchronisers, handshake outputs, serial idle and interrupt
// assumes pins are asynchronous to clock_i and the bus master keeps
// strobes one cycle long and never both at once
`timescale 1ns/1ns
module dual_uart_modem_signals
(
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // register port
  input wire logic [modem_pkg::ADDR_W-1:0] addr_i,
  input wire logic [modem_pkg::DATA_W-1:0] wr_data_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [modem_pkg::DATA_W-1:0] rd_data_o,
  // shared uart input clock pin
  input wire logic uart_clk_i,
  // modem pins, active low inputs
  input modem_pkg::modem_in_s [modem_pkg::NPORT-1:0] modem_n_i,
  input wire logic [modem_pkg::NPORT-1:0] port_serial_in_i,
  // transmit bit from framing logic on clock_i
  input wire logic [modem_pkg::NPORT-1:0] tx_bit_i,
  // modem pins, outputs
  output logic [modem_pkg::NPORT-1:0] terminal_ready_n_o,
  output logic [modem_pkg::NPORT-1:0] request_send_n_o,
  output logic [modem_pkg::NPORT-1:0] port_serial_out_o,
  // towards framing logic
  output logic [modem_pkg::NPORT-1:0] rx_bit_o,
  output logic [modem_pkg::NPORT-1:0] baud_tick_o,
  // interrupt
  output logic irq_o
);
  import modem_pkg::*;

  logic [SYNC_W-1:0] sync_meta;
  logic [SYNC_W-1:0] sync_pins;
  logic uart_clk_s;
  logic [NPORT-1:0] serial_in_s;
  modem_in_s [NPORT-1:0] modem_s;
  logic [7:0] mcr [NPORT];
  logic [7:0] status [NPORT];
  logic [NPORT-1:0] status_rd;
  logic [NPORT-1:0] change;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  logic [7:0] next_rd_data;

  // two flops on every pin; only the second stage feeds logic
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      sync_meta <= SYNC_RESET;
      sync_pins <= SYNC_RESET;
    end
    else
    begin
      sync_meta <= {modem_n_i, port_serial_in_i, uart_clk_i};
      sync_pins <= sync_meta;
    end
  end

  assign uart_clk_s = sync_pins[0];
  assign serial_in_s = sync_pins[NPORT:1];
  assign modem_s = sync_pins[SYNC_W-1:NPORT+1];

  genvar p;
  generate
    for (p = 0; p < NPORT; p++)
    begin : g_port
      assign status_rd[p] = rd_i && port_hit(addr_i, STATUS_BASE, p);

      // status levels and change flags
      modem_port u_status
      (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .modem_n_i(modem_s[p]),
        .mcr_i(mcr[p]),
        .status_rd_i(status_rd[p]),
        .status_o(status[p]),
        .change_o(change[p])
      );

      // each port divides the shared uart clock on its own
      baud_tick u_baud
      (
        .clock_i(clock_i),
        .nrst_i(nrst_i),
        .uart_clk_i(uart_clk_s),
        .tick_o(baud_tick_o[p])
      );

      // modem control register
      always_ff @(posedge clock_i or negedge nrst_i)
      begin
        if (!nrst_i)
          mcr[p] <= MCR_RESET;
        else if (wr_i && port_hit(addr_i, MCR_BASE, p))
          mcr[p] <= wr_data_i & MCR_WMASK;
      end

      // handshake outputs; loopback parks them inactive
      always_ff @(posedge clock_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          terminal_ready_n_o[p] <= INACTIVE_N;
          request_send_n_o[p] <= INACTIVE_N;
        end
        else if (mcr[p][MCR_LOOP])
        begin
          terminal_ready_n_o[p] <= INACTIVE_N;
          request_send_n_o[p] <= INACTIVE_N;
        end
        else
        begin
          terminal_ready_n_o[p] <= ~mcr[p][MCR_DTR];
          request_send_n_o[p] <= ~mcr[p][MCR_RTS];
        end
      end

      // serial path: no handshake input gates the transmitter, by design
      // framing logic owns flow control, not this block
      always_ff @(posedge clock_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          port_serial_out_o[p] <= MARK;
          rx_bit_o[p] <= MARK;
        end
        else if (mcr[p][MCR_LOOP])
        begin
          port_serial_out_o[p] <= MARK;
          rx_bit_o[p] <= tx_bit_i[p];
        end
        else
        begin
          port_serial_out_o[p] <= tx_bit_i[p];
          rx_bit_o[p] <= serial_in_s[p];
        end
      end
    end
  endgenerate

  // sticky interrupt status, write one to clear; a new event wins
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      irq_stat <= IRQ_RESET;
    else if (wr_i && addr_i == IRQ_STAT_OFF)
      irq_stat <= (irq_stat & ~wr_data_i[1:0]) | change;
    else
      irq_stat <= irq_stat | change;
  end

  // mask doubles as the modem status interrupt enable of each port
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      irq_mask <= IRQ_RESET;
    else if (wr_i && addr_i == IRQ_MASK_OFF)
      irq_mask <= wr_data_i[1:0];
  end

  // level interrupt, registered so it comes straight from a flop
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(irq_stat & irq_mask);
  end

  // read mux; unmapped addresses read zero
  always_comb
  begin
    next_rd_data = READ_ZERO;
    if (port_hit(addr_i, STATUS_BASE, 0))
      next_rd_data = status[0];
    else if (port_hit(addr_i, MCR_BASE, 0))
      next_rd_data = mcr[0];
    else if (port_hit(addr_i, STATUS_BASE, 1))
      next_rd_data = status[1];
    else if (port_hit(addr_i, MCR_BASE, 1))
      next_rd_data = mcr[1];
    else if (addr_i == IRQ_STAT_OFF)
      next_rd_data = {6'h00, irq_stat};
    else if (addr_i == IRQ_MASK_OFF)
      next_rd_data = {6'h00, irq_mask};
  end

  // read data stand for exactly the cycle after the strobe
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      rd_data_o <= READ_ZERO;
    else
      rd_data_o <= rd_i ? next_rd_data : READ_ZERO;
  end

endmodule : dual_uart_modem_signals

//--- src/modem_port.sv
// modem status levels and change flags of one serial port
// assumes modem inputs are already synchronised to clock_i
`timescale 1ns/1ns
module modem_port
(
  // clock and reset
  input wire logic clock_i,
  input wire logic nrst_i,
  // synchronised active-low modem inputs
  input modem_pkg::modem_in_s modem_n_i,
  // modem control register and status read strobe
  input wire logic [7:0] mcr_i,
  input wire logic status_rd_i,
  // status register image and level-change pulse
  output logic [7:0] status_o,
  output logic change_o
);
  import modem_pkg::*;

  logic [3:0] lvl;
  logic [3:0] prev;
  logic [3:0] flags;
  logic [3:0] delta;
  logic armed;

  // levels are inverted pins; loopback feeds them from the control bits
  always_comb
  begin
    if (mcr_i[MCR_LOOP])
      lvl = {mcr_i[MCR_OUT2], mcr_i[MCR_OUT1], mcr_i[MCR_DTR],
             mcr_i[MCR_RTS]};
    else
    begin
      lvl[3] = ~modem_n_i.carrier_detect_n;
      lvl[2] = ~modem_n_i.ring_indicate_n;
      lvl[1] = ~modem_n_i.dsr_n;
      lvl[0] = ~modem_n_i.cts_n;
    end
  end

  // armed keeps the first cycle after reset from counting as a change
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      prev <= FLAGS_RESET;
      armed <= 1'b0;
    end
    else
    begin
      prev <= lvl;
      armed <= 1'b1;
    end
  end

  assign delta = armed ? (lvl ^ prev) : FLAGS_RESET;

  // a change in the reading cycle survives the clear
  always_ff @(posedge clock_i or negedge nrst_i)
  begin
    if (!nrst_i)
      flags <= FLAGS_RESET;
    else
      flags <= (flags & ~{4{status_rd_i}}) | delta;
  end

  assign status_o = {lvl, flags};
  assign change_o = |delta;

endmodule : modem_port
